// ### twbc_map.vh
// register map, field positions and codes of the two-wire bus controller
`ifndef TWBC_MAP_VH
`define TWBC_MAP_VH
`define TWBC_OFS_CFG 16'he600
`define TWBC_OFS_CTRL 16'he604
`define TWBC_OFS_STAT 16'he608
`define TWBC_OFS_OADR 16'he60c
`define TWBC_OFS_BUF 16'he610
`define TWBC_CFG_RESET 16'h0000
`define TWBC_CFG_WMASK 16'hff77
`define TWBC_CFG_BRP 15:8
`define TWBC_CFG_SCLEN 6:4
`define TWBC_CFG_SDAEN 2:0
`define TWBC_CTRL_CI 11:10
`define TWBC_CTRL_TRX 7
`define TWBC_CTRL_INT 6
`define TWBC_CTRL_BUM 4
`define TWBC_CTRL_ROLE 3:2
`define TWBC_CTRL_RSC 1
`define TWBC_CTRL_M10 0
`define TWBC_STAT_PROTOCOL_EVENT_IRQ_FLAG 6
`define TWBC_STAT_DATA_EVENT_IRQ_FLAG 5
`define TWBC_STAT_AL 1
`define TWBC_OADR_STYLE 15
`define TWBC_OADR_PRE 14:13
`define TWBC_OADR_ICA 9:0
`define TWBC_ROLE_OFF 2'h0
`define TWBC_ROLE_TGT 2'h1
`define TWBC_ROLE_SM 2'h2
`define TWBC_ROLE_MM 2'h3
`define TWBC_PRE_8 2'h1
`define TWBC_PRE_64 2'h2
`define TWBC_PRE_TOP_8 6'h07
`define TWBC_PRE_TOP_64 6'h3f
`define TWBC_GCALL 8'h00
`define TWBC_TENBIT_HDR 5'h1e
`define TWBC_LAST_DATA 4'h7
`define TWBC_ACK_SLOT 4'h8
`define TWBC_CO_MAX 3'h4
`define TWBC_NPINS 3
`endif

// ### twbc_baud.v
// baud tick generator: four ticks per bus bit
`timescale 1ns/1ps
`default_nettype none
`include "twbc_map.vh"

module twbc_baud #(
  parameter PW = 8
) (
  // system
  input wire clk_i,
  input wire rst_i,
  // settings
  input wire en_i,
  input wire style_i,
  input wire [1:0] pre_i,
  input wire [PW-1:0] val_i,
  // tick
  output reg tick_o
);
  reg [5:0] pre_cnt_r;
  reg [PW-1:0] div_r;
  reg [PW-1:0] acc_r;
  wire [5:0] pre_top = (pre_i == `TWBC_PRE_8) ? `TWBC_PRE_TOP_8 :
                       (pre_i == `TWBC_PRE_64) ? `TWBC_PRE_TOP_64 : 6'h00;
  wire pre_tick = (pre_cnt_r >= pre_top);
  // fractional: add value+1 each pre tick, carry out gives the tick
  wire [PW:0] acc_sum = {1'b0, acc_r} + {1'b0, val_i} + {{PW{1'b0}}, 1'b1};

  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      pre_cnt_r <= 6'h00;
      div_r <= {PW{1'b0}};
      acc_r <= {PW{1'b0}};
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      pre_cnt_r <= pre_tick ? 6'h00 : pre_cnt_r + 6'h01;
      if (pre_tick) begin
        if (style_i) begin
          acc_r <= acc_sum[PW-1:0];
          tick_o <= acc_sum[PW];
        end else if (div_r >= val_i) begin
          div_r <= {PW{1'b0}};
          tick_o <= 1'b1;
        end else begin
          div_r <= div_r + {{(PW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // twbc_baud
`default_nettype wire

// ### twbc_pins.v
// routing of the internal clock and data lines to candidate open-drain pins
`timescale 1ns/1ps
`default_nettype none

module twbc_pins #(
  parameter N = 3
) (
  // routing
  input wire [N-1:0] scl_en_i,
  input wire [N-1:0] sda_en_i,
  // internal lines
  input wire scl_low_i,
  input wire sda_low_i,
  output wire scl_line_o,
  output wire sda_line_o,
  // pins
  input wire [N-1:0] scl_pin_i,
  output wire [N-1:0] scl_pin_o,
  output wire [N-1:0] scl_pin_oe_o,
  input wire [N-1:0] sda_pin_i,
  output wire [N-1:0] sda_pin_o,
  output wire [N-1:0] sda_pin_oe_o
);
  wire [N-1:0] scl_seen;
  wire [N-1:0] sda_seen;
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pin
      // a disconnected pin neither drives nor pulls the line down
      assign scl_pin_o[g] = 1'b0;
      assign sda_pin_o[g] = 1'b0;
      assign scl_pin_oe_o[g] = scl_en_i[g] & scl_low_i;
      assign sda_pin_oe_o[g] = sda_en_i[g] & sda_low_i;
      assign scl_seen[g] = ~scl_en_i[g] | scl_pin_i[g];
      assign sda_seen[g] = ~sda_en_i[g] | sda_pin_i[g];
    end
  endgenerate
  assign scl_line_o = &scl_seen;
  assign sda_line_o = &sda_seen;
endmodule // twbc_pins
`default_nettype wire

// ### twbc_ctrl.v
// two-wire bus controller: wishbone registers, master and target engines
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "twbc_map.vh"

module twbc_ctrl (
  // system
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [15:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // two-wire pins, open drain
  input wire [`TWBC_NPINS-1:0] scl_pin_i,
  output wire [`TWBC_NPINS-1:0] scl_pin_o,
  output wire [`TWBC_NPINS-1:0] scl_pin_oe_o,
  input wire [`TWBC_NPINS-1:0] sda_pin_i,
  output wire [`TWBC_NPINS-1:0] sda_pin_o,
  output wire [`TWBC_NPINS-1:0] sda_pin_oe_o
);
  localparam S_IDLE = 3'h0;
  localparam S_START = 3'h1;
  localparam S_BIT = 3'h2;
  localparam S_WAIT = 3'h3;
  localparam S_RSTART = 3'h4;
  localparam S_STOP = 3'h5;

  function [7:0] lane_byte;
    input [31:0] b;
    input [1:0] i;
    lane_byte = b[{i, 3'b000} +: 8];
  endfunction

  function [3:0] lane_mask;
    input [1:0] ci;
    case (ci)
      2'h0: lane_mask = 4'h1;
      2'h1: lane_mask = 4'h3;
      2'h2: lane_mask = 4'h7;
      default: lane_mask = 4'hf;
    endcase
  endfunction

  // registers
  reg [15:0] cfg_r;
  reg [1:0] ci_r;
  reg trx_r, int_r, bum_r, rsc_r, m10_r;
  reg [1:0] role_r;
  reg style_r;
  reg [1:0] pre_r;
  reg [9:0] ica_r;
  reg [2:0] co_r;
  reg protocol_event_irq_flag_r, data_event_irq_flag_r, bb_r, lrb_r, sla_r, al_r, adrph_r;
  reg [31:0] buf_r;
  reg [3:0] acc_r;
  // master engine
  reg [2:0] state_r;
  reg [1:0] q_r;
  reg [3:0] bitn_r;
  reg [1:0] idx_r;
  reg first_r, lost_r;
  reg [7:0] m_shift_r;
  reg m_scl_low_r, m_sda_low_r;
  // target engine
  reg t_act_r, t_abyte_r, t_ack_r, t_hold_r, t_sda_low_r;
  reg [3:0] t_bitn_r;
  reg [7:0] t_shift_r;
  reg scl_prev_r, sda_prev_r;

  wire scl_line, sda_line, tick;
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i;
  wire hit_cfg = (wb_adr_i == `TWBC_OFS_CFG);
  wire hit_ctrl = (wb_adr_i == `TWBC_OFS_CTRL);
  wire hit_stat = (wb_adr_i == `TWBC_OFS_STAT);
  wire hit_oadr = (wb_adr_i == `TWBC_OFS_OADR);
  wire hit_buf = (wb_adr_i == `TWBC_OFS_BUF);
  wire is_master = (role_r == `TWBC_ROLE_SM) | (role_r == `TWBC_ROLE_MM);
  wire tgt_role = (role_r == `TWBC_ROLE_TGT) | (role_r == `TWBC_ROLE_MM);
  wire [9:0] ica_rd = m10_r ? ica_r : {2'b00, ica_r[7:1], 1'b0};
  wire [31:0] selmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  reg [31:0] rd;
  wire [31:0] wd = (wb_dat_i & selmask) | (rd & ~selmask);
  wire [3:0] acc_nxt = acc_r | wb_sel_i;
  wire buf_done = ((acc_nxt & lane_mask(ci_r)) == lane_mask(ci_r));
  wire m_tx = first_r | trx_r;
  wire [7:0] m_byte = lane_byte(buf_r, idx_r);
  wire [3:0] m_bit = `TWBC_LAST_DATA - bitn_r;
  wire start_seen = scl_line & scl_prev_r & sda_prev_r & ~sda_line;
  wire stop_seen = scl_line & scl_prev_r & ~sda_prev_r & sda_line;
  wire scl_rise = scl_line & ~scl_prev_r;
  wire scl_fall = ~scl_line & scl_prev_r;
  wire t_free = (state_r == S_IDLE) | lost_r;
  wire t_tx = t_act_r & sla_r & ~adrph_r & trx_r;
  wire [7:0] t_byte = lane_byte(buf_r, idx_r);
  wire [3:0] t_bit = `TWBC_LAST_DATA - t_bitn_r;
  wire [7:0] t_in = {t_shift_r[6:0], sda_line};
  wire gcall_hit = (t_shift_r == `TWBC_GCALL);
  wire hit7 = (t_shift_r[7:1] == ica_r[7:1]);
  wire hit10a = (t_shift_r[7:3] == `TWBC_TENBIT_HDR) & (t_shift_r[2:1] == ica_r[9:8]);
  wire hit10b = (t_shift_r == ica_r[7:0]);

  always @* begin
    case (1'b1)
      hit_cfg: rd = {16'h0000, cfg_r};
      hit_ctrl: rd = {20'h00000, ci_r, 2'h0, trx_r, int_r, 1'b0, bum_r, role_r, rsc_r, m10_r};
      hit_stat: rd = {21'h00000, co_r, 1'b0, protocol_event_irq_flag_r, data_event_irq_flag_r, bb_r, lrb_r, sla_r, al_r, adrph_r};
      hit_oadr: rd = {16'h0000, style_r, pre_r, 3'h0, ica_rd};
      hit_buf: rd = buf_r;
      default: rd = 32'h00000000;
    endcase
  end

  twbc_baud #(.PW(8)) u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(is_master),
    .style_i(style_r),
    .pre_i(pre_r),
    .val_i(cfg_r[`TWBC_CFG_BRP]),
    .tick_o(tick)
  );

  twbc_pins #(.N(`TWBC_NPINS)) u_pins (
    .scl_en_i(cfg_r[`TWBC_CFG_SCLEN]),
    .sda_en_i(cfg_r[`TWBC_CFG_SDAEN]),
    .scl_low_i(m_scl_low_r | t_hold_r),
    .sda_low_i(m_sda_low_r | t_sda_low_r | t_ack_r),
    .scl_line_o(scl_line),
    .sda_line_o(sda_line),
    .scl_pin_i(scl_pin_i),
    .scl_pin_o(scl_pin_o),
    .scl_pin_oe_o(scl_pin_oe_o),
    .sda_pin_i(sda_pin_i),
    .sda_pin_o(sda_pin_o),
    .sda_pin_oe_o(sda_pin_oe_o)
  );

  always @(posedge clk_i) begin
    if (rst_i || (role_r == `TWBC_ROLE_OFF && !req)) begin
      if (rst_i) begin
        cfg_r <= `TWBC_CFG_RESET;
        {ci_r, trx_r, int_r, role_r, m10_r} <= 7'h00;
        {style_r, pre_r, ica_r} <= 13'h000;
        buf_r <= 32'h00000000;
        {protocol_event_irq_flag_r, data_event_irq_flag_r, al_r} <= 3'h0;
      end
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      {bum_r, rsc_r, bb_r, lrb_r, sla_r, adrph_r} <= 6'h00;
      co_r <= 3'h0;
      acc_r <= 4'h0;
      state_r <= S_IDLE;
      {q_r, idx_r} <= 4'h0;
      bitn_r <= 4'h0;
      {first_r, lost_r, m_scl_low_r, m_sda_low_r} <= 4'h0;
      m_shift_r <= 8'h00;
      {t_act_r, t_abyte_r, t_ack_r, t_hold_r, t_sda_low_r} <= 5'h00;
      t_bitn_r <= 4'h0;
      t_shift_r <= 8'h00;
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      // bus slave: one wait state, ack for one cycle, unmapped reads zero
      wb_ack_o <= req;
      if (req) wb_dat_o <= rd;
      scl_prev_r <= scl_line;
      sda_prev_r <= sda_line;
      if (wr && hit_cfg) cfg_r <= wd[15:0] & `TWBC_CFG_WMASK;
      if (wr && hit_oadr) begin
        style_r <= wd[`TWBC_OADR_STYLE];
        pre_r <= wd[`TWBC_OADR_PRE];
        ica_r <= wd[`TWBC_OADR_ICA];
      end
      if (wr && hit_ctrl) begin
        ci_r <= wd[`TWBC_CTRL_CI];
        trx_r <= wd[`TWBC_CTRL_TRX];
        int_r <= wd[`TWBC_CTRL_INT];
        role_r <= wd[`TWBC_CTRL_ROLE];
        m10_r <= wd[`TWBC_CTRL_M10];
        rsc_r <= wd[`TWBC_CTRL_RSC] & is_master & bum_r;
        if (!wd[`TWBC_CTRL_BUM]) begin
          bum_r <= 1'b0;
        end else if (!bum_r && is_master) begin
          if (bb_r) al_r <= 1'b1;
          else bum_r <= 1'b1;
        end
      end
      // flags are cleared by writing zero; a hardware set later in this block wins
      if (wr && hit_stat) begin
        if (!wd[`TWBC_STAT_PROTOCOL_EVENT_IRQ_FLAG]) protocol_event_irq_flag_r <= 1'b0;
        if (!wd[`TWBC_STAT_DATA_EVENT_IRQ_FLAG]) data_event_irq_flag_r <= 1'b0;
        if (!wd[`TWBC_STAT_AL]) al_r <= 1'b0;
      end
      if (req && hit_buf) begin
        lrb_r <= 1'b0;
        if (wb_we_i) begin
          buf_r <= (wb_dat_i & selmask) | (buf_r & ~selmask);
          trx_r <= 1'b1;
        end
        if (buf_done) begin
          acc_r <= 4'h0;
          co_r <= 3'h0;
          if (!int_r) data_event_irq_flag_r <= 1'b0;
        end else begin
          acc_r <= acc_nxt;
        end
      end

      // bus busy tracking from the lines themselves
      if (start_seen) bb_r <= 1'b1;
      if (stop_seen) bb_r <= 1'b0;

      // master engine, four quarter ticks per bit
      if (tick) begin
        q_r <= q_r + 2'h1;
        case (state_r)
          S_IDLE: begin
            q_r <= 2'h0;
            if (bum_r) begin
              state_r <= S_START;
              bb_r <= 1'b1;
              lost_r <= 1'b0;
            end
          end
          S_START: begin
            if (q_r == 2'h2) m_sda_low_r <= 1'b1;
            if (q_r == 2'h3) begin
              state_r <= S_BIT;
              {bitn_r, idx_r} <= 6'h00;
              first_r <= 1'b1;
            end
          end
          S_BIT: begin
            if (q_r == 2'h0) begin
              m_scl_low_r <= 1'b1;
              if (bitn_r == `TWBC_ACK_SLOT) m_sda_low_r <= ~m_tx;
              else m_sda_low_r <= m_tx & ~lost_r & ~m_byte[m_bit[2:0]];
            end
            if (q_r == 2'h2) m_scl_low_r <= 1'b0;
            // a target stretching the clock holds the sample point
            if (q_r == 2'h3 && !scl_line) q_r <= 2'h3;
            if (q_r == 2'h3 && scl_line) begin
              bitn_r <= bitn_r + 4'h1;
              if (bitn_r != `TWBC_ACK_SLOT) begin
                m_shift_r <= {m_shift_r[6:0], sda_line};
                if (m_tx && !m_sda_low_r && !sda_line && !lost_r) begin
                  al_r <= 1'b1;
                  lost_r <= 1'b1;
                  if (role_r == `TWBC_ROLE_MM) protocol_event_irq_flag_r <= 1'b1;
                end
              end else begin
                bitn_r <= 4'h0;
                m_sda_low_r <= 1'b0;
                lrb_r <= m_tx & sda_line;
                if (co_r != `TWBC_CO_MAX) co_r <= co_r + 3'h1;
                if (!m_tx) buf_r[{idx_r, 3'b000} +: 8] <= m_shift_r;
                if (first_r && (!m10_r || idx_r != 2'h0)) begin
                  first_r <= 1'b0;
                  if (buf_r[0]) trx_r <= 1'b0;
                end
                if (lost_r) begin
                  // clocked out to the ninth pulse; the target side carries on
                  state_r <= S_IDLE;
                  bum_r <= 1'b0;
                  m_scl_low_r <= 1'b0;
                end else if (m_tx && sda_line) begin
                  state_r <= S_WAIT;
                  protocol_event_irq_flag_r <= 1'b1;
                  idx_r <= 2'h0;
                end else if (idx_r == ci_r) begin
                  state_r <= S_WAIT;
                  data_event_irq_flag_r <= 1'b1;
                  idx_r <= 2'h0;
                end else begin
                  idx_r <= idx_r + 2'h1;
                end
              end
            end
          end
          S_WAIT: begin
            q_r <= 2'h0;
            m_scl_low_r <= 1'b1;
            if (!bum_r) state_r <= S_STOP;
            else if (rsc_r) state_r <= S_RSTART;
            else if (!data_event_irq_flag_r && !protocol_event_irq_flag_r) state_r <= S_BIT;
          end
          S_RSTART: begin
            if (q_r == 2'h0) m_sda_low_r <= 1'b0;
            if (q_r == 2'h1) m_scl_low_r <= 1'b0;
            if (q_r == 2'h2) m_sda_low_r <= 1'b1;
            if (q_r == 2'h3) begin
              rsc_r <= 1'b0;
              state_r <= S_BIT;
              {bitn_r, idx_r} <= 6'h00;
              first_r <= 1'b1;
            end
          end
          S_STOP: begin
            if (q_r == 2'h0) begin
              m_scl_low_r <= 1'b1;
              m_sda_low_r <= 1'b1;
            end
            if (q_r == 2'h1) m_scl_low_r <= 1'b0;
            if (q_r == 2'h2) m_sda_low_r <= 1'b0;
            if (q_r == 2'h3) state_r <= S_IDLE;
          end
          default: state_r <= S_IDLE;
        endcase
      end
      if (bum_r && state_r != S_IDLE) sla_r <= 1'b0;

      // target engine, driven by the bus clock edges
      t_hold_r <= t_act_r & sla_r & (t_bitn_r == 4'h0) & (data_event_irq_flag_r | protocol_event_irq_flag_r)
                  & (t_hold_r | ~scl_line);
      if (!scl_line) begin
        t_sda_low_r <= t_tx & (t_bitn_r != `TWBC_ACK_SLOT) & ~t_byte[t_bit[2:0]];
      end
      if (t_act_r && scl_rise) begin
        if (t_bitn_r != `TWBC_ACK_SLOT) t_shift_r <= t_in;
        else if (t_tx) lrb_r <= sda_line;
      end
      if (t_act_r && scl_fall) begin
        t_bitn_r <= t_bitn_r + 4'h1;
        if (t_bitn_r == `TWBC_LAST_DATA) begin
          if (adrph_r) begin
            if (!t_free) begin
              t_act_r <= 1'b0;
              adrph_r <= 1'b0;
            end else if (gcall_hit || (!m10_r && hit7) || (m10_r && t_abyte_r && hit10b)) begin
              sla_r <= 1'b1;
              protocol_event_irq_flag_r <= 1'b1;
              adrph_r <= 1'b0;
              t_ack_r <= 1'b1;
            end else if (m10_r && !t_abyte_r && hit10a) begin
              t_abyte_r <= 1'b1;
              t_ack_r <= 1'b1;
            end else begin
              t_act_r <= 1'b0;
              adrph_r <= 1'b0;
            end
          end else if (sla_r && !trx_r) begin
            buf_r[{idx_r, 3'b000} +: 8] <= t_shift_r;
            t_ack_r <= 1'b1;
            lrb_r <= 1'b0;
            if (co_r != `TWBC_CO_MAX) co_r <= co_r + 3'h1;
            if (idx_r == ci_r) begin
              data_event_irq_flag_r <= 1'b1;
              idx_r <= 2'h0;
            end else begin
              idx_r <= idx_r + 2'h1;
            end
          end
        end
        if (t_bitn_r == `TWBC_ACK_SLOT) begin
          t_bitn_r <= 4'h0;
          t_ack_r <= 1'b0;
          if (t_tx) begin
            if (co_r != `TWBC_CO_MAX) co_r <= co_r + 3'h1;
            if (idx_r == ci_r) begin
              data_event_irq_flag_r <= 1'b1;
              idx_r <= 2'h0;
            end else begin
              idx_r <= idx_r + 2'h1;
            end
          end
        end
      end
      if (start_seen && tgt_role) begin
        t_act_r <= 1'b1;
        adrph_r <= 1'b1;
        t_abyte_r <= 1'b0;
        t_bitn_r <= 4'h0;
        t_ack_r <= 1'b0;
        sla_r <= 1'b0;
        idx_r <= 2'h0;
      end
      if (stop_seen) begin
        {t_act_r, adrph_r, t_ack_r, sla_r} <= 4'h0;
      end
      if (role_r == `TWBC_ROLE_TGT && lrb_r) trx_r <= 1'b1;
    end
  end
endmodule // twbc_ctrl
`default_nettype wire

// ### twbc_ctrl_props.sv
// port-level assertions for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
`include "twbc_map.vh"
module twbc_ctrl_props (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // pins
  input wire logic [`TWBC_NPINS-1:0] scl_pin_i,
  input wire logic [`TWBC_NPINS-1:0] scl_pin_o,
  input wire logic [`TWBC_NPINS-1:0] scl_pin_oe_o,
  input wire logic [`TWBC_NPINS-1:0] sda_pin_i,
  input wire logic [`TWBC_NPINS-1:0] sda_pin_o,
  input wire logic [`TWBC_NPINS-1:0] sda_pin_oe_o
);
  logic [2:0] scl_en_r;
  logic [2:0] sda_en_r;
  logic m10_r;
  logic bum_r;
  logic [1:0] role_r;
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire logic rd_take = take && !wb_we_i;
  wire logic wr_ctl = take && wb_we_i && wb_sel_i[0] && wb_adr_i == `TWBC_OFS_CTRL;
  // shadow of the software-written enables; hardware never changes the pin enables, mode or role, but can clear busy
  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_en_r <= 3'h0;
      sda_en_r <= 3'h0;
      m10_r <= 1'h0;
      bum_r <= 1'h0;
      role_r <= 2'h0;
    end else begin
      if (take && wb_we_i && wb_sel_i[0] && wb_adr_i == `TWBC_OFS_CFG) begin
        scl_en_r <= wb_dat_i[6:4];
        sda_en_r <= wb_dat_i[2:0];
      end
      if (wr_ctl) begin
        m10_r <= wb_dat_i[0];
        bum_r <= wb_dat_i[4];
        role_r <= wb_dat_i[3:2];
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // busy only starts from an idle master role that is already in force
  sequence bum_set_s;
    wr_ctl && wb_dat_i[4] && !bum_r && role_r == `TWBC_ROLE_SM && scl_en_r[0] && sda_en_r[0];
  endsequence
  sequence bum_clr_s;
    wr_ctl && !wb_dat_i[4] && bum_r && scl_en_r[0] && sda_en_r[0];
  endsequence
  sequence start_s;
    scl_pin_i[0] && $fell(sda_pin_i[0]);
  endsequence
  sequence stop_s;
    scl_pin_i[0] && $rose(sda_pin_i[0]);
  endsequence
  ack_latency_a: assert property (take |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  open_drain_a: assert property (scl_pin_o == 3'h0 && sda_pin_o == 3'h0)
    else $error("pin driven high");
  scl_route_a: assert property ((scl_pin_oe_o & ~scl_en_r) == 3'h0)
    else $error("disconnected clock pin driven");
  sda_route_a: assert property ((sda_pin_oe_o & ~sda_en_r) == 3'h0)
    else $error("disconnected data pin driven");
  unmapped_zero_a: assert property (rd_take && wb_adr_i > 16'he613 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  cfg_reserved_a: assert property (rd_take && wb_adr_i == `TWBC_OFS_CFG |=>
    wb_dat_o[31:16] == 16'h0 && !wb_dat_o[7] && !wb_dat_o[3])
    else $error("config reserved bits not zero");
  own_addr_a: assert property (rd_take && wb_adr_i == `TWBC_OFS_OADR && !m10_r |=>
    wb_dat_o[9:8] == 2'h0 && !wb_dat_o[0])
    else $error("seven-bit address bits not zero");
  start_gen_a: assert property (bum_set_s |-> ##[1:100] start_s)
    else $error("no start after busy set");
  stop_gen_a: assert property (bum_clr_s |-> ##[1:200] stop_s)
    else $error("no stop after busy cleared");
endmodule // twbc_ctrl_props
`default_nettype wire

// ### twbc_tgt_model.sv
// behavioural target on the two-wire bus: acks one address, counts starts and stops
`timescale 1ns/1ps
`default_nettype none
module twbc_tgt_model #(
  parameter logic [6:0] ADDR = 7'h52
) (
  // clock
  input wire logic clk_i,
  // bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_low_o,
  // observation
  output logic [7:0] byte_o,
  output logic [3:0] starts_o,
  output logic [3:0] stops_o
);
  logic scl_r = 1'h1;
  logic sda_r = 1'h1;
  logic armed_r = 1'h0;
  logic [3:0] bit_r = 4'h0;
  logic [7:0] sh_r = 8'h0;
  initial begin
    sda_low_o = 1'h0;
    byte_o = 8'h0;
    starts_o = 4'h0;
    stops_o = 4'h0;
  end
  // only the address byte is judged; later bytes are left to the pull-up
  always @(posedge clk_i) begin
    scl_r <= scl_i;
    sda_r <= sda_i;
    if (scl_i && scl_r && sda_r && !sda_i) begin
      starts_o <= starts_o + 4'h1;
      bit_r <= 4'h0;
      armed_r <= 1'h1;
    end else if (scl_i && scl_r && !sda_r && sda_i) begin
      stops_o <= stops_o + 4'h1;
      armed_r <= 1'h0;
    end else if (armed_r && scl_i && !scl_r) begin
      sh_r <= {sh_r[6:0], sda_i};
      bit_r <= bit_r + 4'h1;
    end else if (armed_r && !scl_i && scl_r) begin
      if (bit_r == 4'h8) begin
        byte_o <= sh_r;
        sda_low_o <= sh_r[7:1] == ADDR;
      end
      if (bit_r == 4'h9) begin
        sda_low_o <= 1'h0;
        armed_r <= 1'h0;
      end
    end
  end
endmodule // twbc_tgt_model
`default_nettype wire

// ### tb.sv
// self-checking bench for the two-wire bus controller
`timescale 1ns/1ps
`default_nettype none
`include "twbc_map.vh"
bind twbc_ctrl twbc_ctrl_props u_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .scl_pin_i(scl_pin_i), .scl_pin_o(scl_pin_o), .scl_pin_oe_o(scl_pin_oe_o),
  .sda_pin_i(sda_pin_i), .sda_pin_o(sda_pin_o), .sda_pin_oe_o(sda_pin_oe_o));
module tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, tgt_low;
  logic [15:0] wb_adr_i;
  logic [3:0] wb_sel_i, tgt_starts, tgt_stops;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [2:0] scl_pin_i, scl_pin_o, scl_pin_oe_o, sda_pin_i, sda_pin_o, sda_pin_oe_o;
  logic [7:0] tgt_byte;
  int error_cnt, checked;
  // pull-ups on every pin; the target only shares data pin 0
  assign scl_pin_i = ~scl_pin_oe_o;
  assign sda_pin_i = ~(sda_pin_oe_o | {2'h0, tgt_low});
  twbc_ctrl DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scl_pin_i(scl_pin_i), .scl_pin_o(scl_pin_o),
    .scl_pin_oe_o(scl_pin_oe_o), .sda_pin_i(sda_pin_i), .sda_pin_o(sda_pin_o),
    .sda_pin_oe_o(sda_pin_oe_o));
  twbc_tgt_model u_tgt (.clk_i(clk_i), .scl_i(scl_pin_i[0]), .sda_i(sda_pin_i[0]),
    .sda_low_o(tgt_low), .byte_o(tgt_byte), .starts_o(tgt_starts), .stops_o(tgt_stops));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic single cycle; read data lands in q at the ack edge
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    if (n >= 50) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic poll(input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do begin
      wb(1'h0, `TWBC_OFS_STAT, 32'h0);
      n++;
    end while ((q & m) !== v && n < 300);
    if ((q & m) !== v) begin
      error_cnt++;
      complete_run();
    end
  endtask
  task automatic t_regs();
    wb(1'h0, `TWBC_OFS_CFG, 32'h0);
    chk(q, 32'h0);
    wb(1'h0, `TWBC_OFS_STAT, 32'h0);
    chk(q, 32'h0);
    wb(1'h1, `TWBC_OFS_CFG, 32'hffffffff);
    wb(1'h0, `TWBC_OFS_CFG, 32'h0);
    chk(q, 32'h0000ff77);
    wb(1'h1, 16'he6f0, 32'hffffffff);
    wb(1'h0, 16'he6f0, 32'h0);
    chk(q, 32'h0);
    for (int i = 3; i >= 0; i--) begin
      wb(1'h1, `TWBC_OFS_CTRL, {28'h0, i[1:0], 2'h0});
      wb(1'h0, `TWBC_OFS_CTRL, 32'h0);
      chk(q & 32'hc, {28'h0, i[1:0], 2'h0});
    end
  endtask
  task automatic t_oadr();
    for (int i = 0; i < 3; i++) begin
      wb(1'h1, `TWBC_OFS_OADR, {16'h0, i[0], i[1:0], 13'h3ff});
      wb(1'h0, `TWBC_OFS_OADR, 32'h0);
      chk(q, {16'h0, i[0], i[1:0], 13'h0fe});
    end
    wb(1'h1, `TWBC_OFS_CTRL, 32'h1);
    wb(1'h1, `TWBC_OFS_OADR, 32'h0000a3ff);
    wb(1'h0, `TWBC_OFS_OADR, 32'h0);
    chk(q, 32'h0000a3ff);
    wb(1'h1, `TWBC_OFS_CTRL, 32'h0c00);
  endtask
  task automatic t_buf();
    wb(1'h1, `TWBC_OFS_BUF, 32'h44332211);
    wb(1'h0, `TWBC_OFS_BUF, 32'h0);
    chk(q, 32'h44332211);
  endtask
  task automatic t_master();
    wb(1'h1, `TWBC_OFS_CFG, 32'h0111);
    // reciprocal, no pre-division: a baud tick every two clocks keeps the bytes short
    wb(1'h1, `TWBC_OFS_OADR, 32'h0);
    wb(1'h1, `TWBC_OFS_BUF, 32'ha4);
    // busy is only accepted once the master role is in force
    wb(1'h1, `TWBC_OFS_CTRL, 32'h0008);
    wb(1'h1, `TWBC_OFS_CTRL, 32'h0018);
    poll(32'h20, 32'h20);
    chk(q & 32'h1c, 32'h10);
    chk({24'h0, tgt_byte}, 32'ha4);
    wb(1'h1, `TWBC_OFS_BUF, 32'hb0);
    wb(1'h0, `TWBC_OFS_STAT, 32'h0);
    chk(q & 32'h20, 32'h0);
    // the target judges only the address, so the data byte ends in a nack
    poll(32'h40, 32'h40);
    chk(q & 32'h18, 32'h18);
    wb(1'h1, `TWBC_OFS_CTRL, 32'h009a);
    wb(1'h1, `TWBC_OFS_STAT, 32'h0);
    poll(32'h40, 32'h40);
    chk(q & 32'h18, 32'h18);
    wb(1'h0, `TWBC_OFS_CTRL, 32'h0);
    chk(q & 32'h12, 32'h10);
    chk({28'h0, tgt_starts}, 32'h2);
    wb(1'h0, `TWBC_OFS_BUF, 32'h0);
    wb(1'h0, `TWBC_OFS_STAT, 32'h0);
    chk(q & 32'h8, 32'h0);
    wb(1'h1, `TWBC_OFS_CTRL, 32'h0008);
    poll(32'h10, 32'h0);
    chk({28'h0, tgt_stops}, 32'h1);
  endtask
  initial begin
    rst_i = 1'h1;
    wb_cyc_i = 1'h0;
    wb_stb_i = 1'h0;
    wb_we_i = 1'h0;
    wb_adr_i = 16'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    error_cnt = 0;
    checked = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    t_regs();
    t_oadr();
    t_buf();
    t_master();
    complete_run();
  end
endmodule // tb
`default_nettype wire
